// ==== hdl/mixed_status_regs.vh ====
// constants for the mixed status register block of a dual card interface
// assumes a single core clock and an 8-bit host bus with separate strobes
`ifndef MIXED_STATUS_REGS_VH
`define MIXED_STATUS_REGS_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define ADDR_MIXED_STATUS 4'hC
`define ADDR_HOLDING      4'hD
`define ADDR_TIMEOUT_CTL  4'h8

// ----------------------------------------
// bit positions
// ----------------------------------------
`define BIT_CLOCK_SWITCH_DONE   7
`define BIT_FE      6
`define BIT_BGT     5
`define BIT_CONTROL_READY    4
`define BIT_PR2     3
`define BIT_PR1     2
`define BIT_AUX     1
`define BIT_TBRB    0

// ----------------------------------------
// timing
// ----------------------------------------
`define GUARD_T1_ETU    5'h16
`define GUARD_T0_ETU    5'h10
`define ACCESS_DELAY    2'h3
`define ETU_W           16

`endif

// ==== hdl/sync2.v ====
// two-flop synchroniser for one pin level
// assumes the pin is asynchronous to the core clock
`timescale 1ns/10ps
`default_nettype none
module sync2
(
   // clock and reset
   input  wire CORE_CLK,
   input  wire RST,
   // level in and out
   input  wire d,
   output wire q
);
   reg meta_q;
   reg sync_q;

   // first stage is read only by the second
   always @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end
      else
      begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end
   assign q = sync_q;
endmodule // sync2
`default_nettype wire

// ==== hdl/guard_timer.v ====
// block guard time counter: counts ETUs after each start bit
// assumes etu_tick pulses once per ETU and start_bit is one cycle long
`include "mixed_status_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module guard_timer
(
   // clock and reset
   input  wire CORE_CLK,
   input  wire RST,
   // control
   input  wire t1_mode,
   input  wire start_bit,
   input  wire etu_tick,
   // result
   output wire elapsed
);
   reg  [4:0] cnt_q;
   reg        done_q;
   wire [4:0] limit = t1_mode ? `GUARD_T1_ETU : `GUARD_T0_ETU;

   // a start bit restarts the count and drops the flag, whether or not the count has expired
   always @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         cnt_q  <= 5'h00;
         done_q <= 1'b0;
      end
      else if (start_bit)
      begin
         cnt_q  <= 5'h00;
         done_q <= 1'b0;
      end
      else if (etu_tick && !done_q)
      begin
         if (cnt_q + 5'h01 >= limit)
            done_q <= 1'b1;
         cnt_q <= cnt_q + 5'h01;
      end
   end
   assign elapsed = done_q;
endmodule // guard_timer
`default_nettype wire

// ==== hdl/mixed_status.v ====
// mixed status register of the card uart: read-only byte at 0Ch
// assumes the host strobes are already on the core clock; pins are not
`include "mixed_status_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module mixed_status
(
   // clock and reset
   input  wire       CORE_CLK,
   input  wire       RST,
   // host bus
   input  wire [3:0] ADDR,
   input  wire       RD_STB,
   input  wire       WR_STB,
   output reg  [7:0] RDATA,
   output wire       FIFO_CTL_WR,
   // uart events from the datapath
   input  wire       UART_ENABLE_CTL,
   input  wire       T1_MODE,
   input  wire       TX_MODE,
   input  wire       FIFO_EMPTY,
   input  wire       FIFO_FULL,
   input  wire       CHAR_SENT,
   input  wire       START_BIT,
   input  wire       ETU_TICK,
   // clock switch completion, to oscillator and to crystal
   input  wire       SWITCH_TO_OSC_DONE,
   input  wire       SWITCH_TO_XTAL_DONE,
   // pins
   input  wire       SLOT1_PRESENCE_CONTACT,
   input  wire       SLOT2_PRESENCE_CONTACT,
   input  wire       AUX_IRQ_PIN,
   // view of the register
   output wire [7:0] MIXED_STATUS
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   wire [2:0] pin_raw = {AUX_IRQ_PIN, SLOT2_PRESENCE_CONTACT, SLOT1_PRESENCE_CONTACT};
   wire [2:0] pin_s;
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : g_sync
         sync2 u_sync
         (
            .CORE_CLK (CORE_CLK),
            .RST      (RST),
            .d        (pin_raw[g]),
            .q        (pin_s[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // decode
   // ----------------------------------------
   function hit;
      input [3:0] a;
      input [3:0] target;
      begin
         hit = (a == target);
      end
   endfunction

   wire tx_write  = WR_STB && hit(ADDR, `ADDR_HOLDING);
   wire rx_read   = RD_STB && hit(ADDR, `ADDR_HOLDING);
   wire toc_write = WR_STB && hit(ADDR, `ADDR_TIMEOUT_CTL);
   assign FIFO_CTL_WR = WR_STB && hit(ADDR, `ADDR_MIXED_STATUS);

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg       clock_switch_done_q;
   reg       tbrb_q;
   reg       tx_mode_q;
   reg [1:0] delay_q;
   wire      guard;

   guard_timer u_guard
   (
      .CORE_CLK  (CORE_CLK),
      .RST       (RST),
      .t1_mode   (T1_MODE),
      .start_bit (START_BIT),
      .etu_tick  (ETU_TICK),
      .elapsed   (guard)
   );

   // clock switch completion flag
   always @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         clock_switch_done_q <= 1'b0;
      else if (SWITCH_TO_OSC_DONE)
         clock_switch_done_q <= 1'b1;
      else if (SWITCH_TO_XTAL_DONE)
         clock_switch_done_q <= 1'b0;
   end

   // access delay: a tx write or rx read clears the flag after three cycles,
   // and control-ready stays low during that window so fast hosts can wait
   always @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         delay_q <= 2'h0;
      else if (tx_write || rx_read || toc_write)
         delay_q <= `ACCESS_DELAY;
      else if (delay_q != 2'h0)
         delay_q <= delay_q - 2'h1;
   end
   reg pend_q;
   always @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         pend_q <= 1'b0;
      else if (tx_write || rx_read)
         pend_q <= 1'b1;
      else if (delay_q == 2'h1)
         pend_q <= 1'b0;
   end
   wire delayed_clear = pend_q && (delay_q == 2'h1);

   // tx/rx flag; set events win over delayed and rx clears arriving together, disable wins over both
   wire to_tx = TX_MODE && !tx_mode_q;
   wire to_rx = !TX_MODE && tx_mode_q;
   always @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         tbrb_q    <= 1'b0;
         tx_mode_q <= 1'b0;
      end
      else
      begin
         tx_mode_q <= TX_MODE;
         if (!UART_ENABLE_CTL)
            tbrb_q <= 1'b0;
         else if (to_tx || FIFO_FULL || CHAR_SENT)
            tbrb_q <= 1'b1;
         else if (delayed_clear || to_rx)
            tbrb_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // register assembly and read port
   // ----------------------------------------
   wire control_ready = (delay_q == 2'h0);
   assign MIXED_STATUS = {clock_switch_done_q, FIFO_EMPTY, guard, control_ready,
                          pin_s[1], pin_s[0], pin_s[2], tbrb_q};

   // status byte reads have no side effects; nothing here feeds an interrupt
   always @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         RDATA <= 8'h00;
      else if (RD_STB && hit(ADDR, `ADDR_MIXED_STATUS))
         RDATA <= MIXED_STATUS;
   end
endmodule // mixed_status
`default_nettype wire

// ==== verification/mixed_status_assertions.sv ====
// port checker for the mixed status register block
// assumes one core clock and the design's own strobes
`timescale 1ns/10ps
`default_nettype none
module mixed_status_assertions
(
   // clock, reset and host bus
   input wire logic       CORE_CLK,
   input wire logic       RST,
   input wire logic [3:0] ADDR,
   input wire logic       RD_STB,
   input wire logic       WR_STB,
   input wire logic [7:0] RDATA,
   input wire logic       FIFO_CTL_WR,
   // events and view
   input wire logic       UART_ENABLE_CTL,
   input wire logic       FIFO_EMPTY,
   input wire logic       SWITCH_TO_OSC_DONE,
   input wire logic       SWITCH_TO_XTAL_DONE,
   input wire logic       AUX_IRQ_PIN,
   input wire logic [7:0] MIXED_STATUS
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   property p_ctl; FIFO_CTL_WR == (WR_STB && ADDR == 4'hC); endproperty
   a_ctl: assert property (p_ctl) else $error("fifo control strobe wrong");
   property p_rd; RD_STB && ADDR == 4'hC |=> RDATA == $past(MIXED_STATUS); endproperty
   a_rd: assert property (p_rd) else $error("read data wrong");
   property p_fe; MIXED_STATUS[6] == FIFO_EMPTY; endproperty
   a_fe: assert property (p_fe) else $error("fifo empty bit wrong");
   property p_osc; SWITCH_TO_OSC_DONE && !SWITCH_TO_XTAL_DONE |=> MIXED_STATUS[7]; endproperty
   a_osc: assert property (p_osc) else $error("switch bit not set");
   property p_xt; SWITCH_TO_XTAL_DONE && !SWITCH_TO_OSC_DONE |=> !MIXED_STATUS[7]; endproperty
   a_xt: assert property (p_xt) else $error("switch bit not cleared");
   property p_aux; AUX_IRQ_PIN [*3] |-> MIXED_STATUS[1]; endproperty
   a_aux: assert property (p_aux) else $error("aux pin bit wrong");
   property p_dis; !UART_ENABLE_CTL |=> !MIXED_STATUS[0]; endproperty
   a_dis: assert property (p_dis) else $error("disable did not clear");
   // ready stays low for the access delay, flag already clear when it returns
   property p_rdy; WR_STB && ADDR == 4'hD |=> !MIXED_STATUS[4] [*3] ##1 (MIXED_STATUS[4] && !MIXED_STATUS[0]);
   endproperty
   a_rdy: assert property (p_rdy) else $error("ready or flag timing wrong");
endmodule // mixed_status_assertions
bind mixed_status mixed_status_assertions u_chk (.*);
`default_nettype wire

// ==== verification/card_host.sv ====
// host model: strobes on the falling edge, one-cycle pulses
// assumes the design takes requests on the rising edge
`timescale 1ns/10ps
`default_nettype none
module card_host
(
   input wire logic       CORE_CLK,
   input wire logic [7:0] RDATA,
   input wire logic [7:0] MIXED_STATUS,
   output var logic [3:0] ADDR = 4'h0,
   output var logic       RD_STB = 1'b0,
   output var logic       WR_STB = 1'b0
);
   // read data is taken one cycle after the strobe
   task rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge CORE_CLK); ADDR = a; RD_STB = 1'b1;
      @(negedge CORE_CLK); RD_STB = 1'b0; d = RDATA;
   endtask
   // a fast host waits for ready, bounded so it never hangs
   task wr(input logic [3:0] a);
      for (int i = 0; i < 8 && !MIXED_STATUS[4]; i++) @(negedge CORE_CLK);
      // a ready bit that never returns is a failure, not a silent write
      if (!MIXED_STATUS[4]) mixed_status_tb.mismatches++;
      @(negedge CORE_CLK); ADDR = a; WR_STB = 1'b1;
      @(negedge CORE_CLK); WR_STB = 1'b0;
   endtask
endmodule // card_host
`default_nettype wire

// ==== verification/mixed_status_tb.sv ====
// self-checking bench for the mixed status register
// assumes card_host and the bound checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module mixed_status_tb;
   logic CORE_CLK = 0, RST = 1, RD_STB, WR_STB, FIFO_CTL_WR;
   logic UART_ENABLE_CTL = 1, T1_MODE = 0, TX_MODE = 0, FIFO_EMPTY = 1, FIFO_FULL = 0, CHAR_SENT = 0;
   logic START_BIT = 0, ETU_TICK = 0, SWITCH_TO_OSC_DONE = 0, SWITCH_TO_XTAL_DONE = 0;
   logic SLOT1_PRESENCE_CONTACT = 0, SLOT2_PRESENCE_CONTACT = 0, AUX_IRQ_PIN = 0;
   logic [3:0] ADDR;
   logic [7:0] RDATA, MIXED_STATUS, d;
   int mismatches = 0, n_checks = 0, n;
   always #10 CORE_CLK = ~CORE_CLK;
   mixed_status u_dut (.*);
   card_host u_host (.*);
   task chk(input string s, input logic [7:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task results;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task cyc(int k); repeat (k) @(negedge CORE_CLK); endtask
   // gap after the pulse keeps two pulses from meeting in one time step
   task automatic pulse(ref logic s); s = 1; cyc(1); s = 0; cyc(1); endtask
   task rst; RST = 1; cyc(3); RST = 0; endtask
   initial begin #1000000; mismatches++; results; end
   initial
   begin
      rst;
      u_host.rd(4'hC, d); chk("reset", d, 8'h50);
      TX_MODE = 1; cyc(3); chk("rx to tx", MIXED_STATUS[0], 8'h01);
      u_host.rd(4'hC, d); chk("no side effect", MIXED_STATUS[0], 8'h01);
      u_host.wr(4'hC); chk("write ignored", MIXED_STATUS[0], 8'h01);
      u_host.wr(4'hD); cyc(4); chk("tx write", MIXED_STATUS[4:0], 8'h10);
      FIFO_FULL = 1; cyc(3); chk("fifo full", MIXED_STATUS[0], 8'h01);
      UART_ENABLE_CTL = 0; cyc(2); chk("disable", MIXED_STATUS[0], 8'h00);
      FIFO_FULL = 0; UART_ENABLE_CTL = 1; pulse(CHAR_SENT); chk("sent", MIXED_STATUS[0], 8'h01);
      TX_MODE = 0; cyc(3); chk("tx to rx", MIXED_STATUS[0], 8'h00);
      pulse(CHAR_SENT); u_host.rd(4'hD, d); cyc(4); chk("fifo read", MIXED_STATUS[0], 8'h00);
      pulse(SWITCH_TO_OSC_DONE); cyc(1); chk("to osc", MIXED_STATUS[7], 8'h01);
      pulse(SWITCH_TO_XTAL_DONE); cyc(1); chk("to xtal", MIXED_STATUS[7], 8'h00);
      FIFO_EMPTY = 0; #1 chk("fifo loaded", MIXED_STATUS[6], 8'h00);
      // a timeout control write holds ready low for the access delay
      u_host.wr(4'h8); chk("toc busy", MIXED_STATUS[4], 8'h00);
      cyc(3); chk("toc ready", MIXED_STATUS[4], 8'h01);
      // one pin at a time so a swapped bit shows
      for (int i = 0; i < 4; i++)
      begin
         {SLOT2_PRESENCE_CONTACT, SLOT1_PRESENCE_CONTACT, AUX_IRQ_PIN} = 3'h7 & (3'h1 << i); cyc(3);
         chk("pins", MIXED_STATUS[3:1], 8'h07 & (8'h01 << i));
      end
      for (int m = 0; m < 2; m++)
      begin
         T1_MODE = m[0]; rst; n = m ? 22 : 16;
         pulse(START_BIT); repeat (n - 1) pulse(ETU_TICK);
         chk("guard early", MIXED_STATUS[5], 8'h00);
         pulse(START_BIT); repeat (n - 1) pulse(ETU_TICK);
         chk("guard restart", MIXED_STATUS[5], 8'h00);
         pulse(ETU_TICK); cyc(1); chk("guard done", MIXED_STATUS[5], 8'h01);
      end
      results;
   end
endmodule // mixed_status_tb
`default_nettype wire
